// *** core/igc_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "igc_consts.svh"

// Notes on behaviour
// - The controller leaves at least 1.5 us between one transistor of a phase turning off and the other on.
// - Every high and low pulse on a command input lasts at least 0.5 us, except a high pulse cut short by a fault or shutdown stop.
// - The PWM carrier runs no faster than 20 kHz.
// - The controller always drives the command lines to a defined level.
// - After a fault the controller drives all commands low well inside 5 ms.
// - On a low fault line the controller stops the motor at once.
// - After a fault stop the controller waits at least 2 s before commanding again.
// - A controller shutdown pulse and any high level on the fault line last at least 3.0 us.
module igc_ctrl (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire igc_pkg::igc_req_s req_in,
	input wire logic shutdown_req_in,
	input wire logic fault_line_in,
	output logic fault_line_out,
	output logic fault_line_oe_out,
	output igc_pkg::igc_gate_s gate_out,
	output logic fault_active_out,
	output logic ready_out
);
	import igc_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	// The two sync stages bring the shared fault line into this clock domain.
	// The mode counter times the shutdown guard in run, the shutdown pulse itself
	// and the restart hold-off, so only one of those spans is ever running.
	// The carrier counter runs freely from reset and paces every gate change except the drop on a fault or shutdown.
	// Per phase, the high and low counters hold the minimum pulse width of
	// their own command, and the dead counter holds off the opposite side after
	// either command has turned off.
	typedef struct packed {
		logic sync1;
		logic sync2;
		igc_mode_e mode;
		logic [`IGC_CNT_W-1:0] mode_cnt;
		logic [`IGC_CNT_W-1:0] carrier_cnt;
		igc_gate_s gate;
		logic [2:0][15:0] hcnt;
		logic [2:0][15:0] lcnt;
		logic [2:0][15:0] dcnt;
	} igc_state_s;

	igc_state_s st;
	igc_state_s next_st;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	// Every span is rounded up to whole clock cycles, so the controller never
	// undercuts a minimum when the clock rate does not divide it evenly.
	// The per-phase counters are sixteen bits wide, which is ample for the
	// pulse and dead spans at this clock rate.
	localparam logic [15:0] MINPW = 16'(`IGC_MINPW_CYC);
	localparam logic [15:0] DEAD = 16'(`IGC_DEAD_CYC);
	localparam logic [`IGC_CNT_W-1:0] SHDN = `IGC_CNT_W'(`IGC_SHDN_CYC);
	localparam logic [`IGC_CNT_W-1:0] PERIOD = `IGC_CNT_W'(`IGC_PERIOD_CYC);

	// The restart hold-off is a parameter so that a short test run can shrink it.
	// In hardware it must stay at its default of two seconds.
	parameter logic [`IGC_CNT_W-1:0] RESTART_CYC = `IGC_CNT_W'(`IGC_RESTART_CYC);

	// ----------------------------------------
	// Derived flags
	// ----------------------------------------
	// A fault is acted on from the second sync stage only, never from the first,
	// so a metastable first stage cannot reach the gate logic.
	logic fault_seen;
	logic carrier_tick;

	assign fault_seen = ~st.sync2;
	assign carrier_tick = (st.carrier_cnt == PERIOD - `IGC_CNT_W'(1));

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.sync1 = fault_line_in;
		next_st.sync2 = st.sync1;
		next_st.carrier_cnt = carrier_tick ? '0 : st.carrier_cnt + `IGC_CNT_W'(1);
		for (int p = 0; p < `IGC_PHASES; p++) begin
			if (st.hcnt[p] != 16'h0000) begin
				next_st.hcnt[p] = st.hcnt[p] - 16'h0001;
			end
			if (st.lcnt[p] != 16'h0000) begin
				next_st.lcnt[p] = st.lcnt[p] - 16'h0001;
			end
			if (st.dcnt[p] != 16'h0000) begin
				next_st.dcnt[p] = st.dcnt[p] - 16'h0001;
			end
		end
		unique case (st.mode)
			IGC_RUN: begin
				if (fault_seen) begin
					// Commands drop in the cycle after the sync stage sees low, far inside 5 ms.
					next_st.gate = '0;
					next_st.mode = IGC_WAIT;
					next_st.mode_cnt = '0;
				end else if (shutdown_req_in && st.mode_cnt >= SHDN) begin
					// The line has stood high for the minimum span before it is pulled.
					// A request that comes too early simply waits here.
					next_st.gate = '0;
					next_st.mode = IGC_SHDN;
					next_st.mode_cnt = '0;
				end else begin
					if (st.mode_cnt < SHDN) begin
						next_st.mode_cnt = st.mode_cnt + `IGC_CNT_W'(1);
					end
					// Requests are sampled only on carrier edges, capping the switching rate.
					if (carrier_tick) begin
						for (int p = 0; p < `IGC_PHASES; p++) begin
							// Turning off waits for the on pulse to reach minimum width.
							if (st.gate.high_side_command[p] && !req_in.high_req[p] && st.hcnt[p] == 16'h0000) begin
								next_st.gate.high_side_command[p] = 1'b0;
								next_st.hcnt[p] = MINPW;
								next_st.dcnt[p] = DEAD;
							end
							if (st.gate.low_side_command[p] && !req_in.low_req[p] && st.lcnt[p] == 16'h0000) begin
								next_st.gate.low_side_command[p] = 1'b0;
								next_st.lcnt[p] = MINPW;
								next_st.dcnt[p] = DEAD;
							end
							// The opposite side must be off and the dead time spent.
							if (!st.gate.high_side_command[p] && req_in.high_req[p] && !req_in.low_req[p]
								&& !st.gate.low_side_command[p] && st.dcnt[p] == 16'h0000
								&& st.hcnt[p] == 16'h0000) begin
								next_st.gate.high_side_command[p] = 1'b1;
								next_st.hcnt[p] = MINPW;
							end else if (!st.gate.low_side_command[p] && req_in.low_req[p] && !req_in.high_req[p]
								&& !st.gate.high_side_command[p] && st.dcnt[p] == 16'h0000
								&& st.lcnt[p] == 16'h0000) begin
								next_st.gate.low_side_command[p] = 1'b1;
								next_st.lcnt[p] = MINPW;
							end
						end
					end
				end
			end
			IGC_SHDN: begin
				// The pulled line reads back as a fault, which is ignored here and
				// instead stretches the hold-off once the pull is released.
				next_st.gate = '0;
				next_st.mode_cnt = st.mode_cnt + `IGC_CNT_W'(1);
				if (st.mode_cnt >= SHDN - `IGC_CNT_W'(1) && !shutdown_req_in) begin
					next_st.mode = IGC_WAIT;
					next_st.mode_cnt = '0;
				end
			end
			IGC_WAIT: begin
				// The hold-off restarts for as long as the line stays low, so a fault
				// that repeats never lets the motor restart early.
				next_st.gate = '0;
				if (fault_seen) begin
					next_st.mode_cnt = '0;
				end else if (st.mode_cnt >= RESTART_CYC - `IGC_CNT_W'(1)) begin
					next_st.mode = IGC_RUN;
					next_st.mode_cnt = '0;
				end else begin
					next_st.mode_cnt = st.mode_cnt + `IGC_CNT_W'(1);
				end
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st <= '0;
			st.sync1 <= 1'b1;
			st.sync2 <= 1'b1;
			// Start in the hold-off state so a power-up is treated like a fault restart.
			st.mode <= IGC_WAIT;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// The gate commands come straight from flip-flops, so they are always at a
	// defined level and carry no combinational glitches to the power stage.
	// The fault line is open-drain: the data bit is fixed low and only the enable
	// moves, so the controller can never fight the pull-up or the device.
	assign gate_out = st.gate;
	assign fault_line_out = 1'b0;
	assign fault_line_oe_out = (st.mode == IGC_SHDN);
	assign fault_active_out = (st.mode != IGC_RUN);
	assign ready_out = (st.mode == IGC_RUN);
endmodule // igc_ctrl

`default_nettype wire

// *** core/igc_consts.svh ***
`ifndef IGC_CONSTS_SVH
`define IGC_CONSTS_SVH

`define IGC_CLK_MHZ 50
`define IGC_DEAD_NS 1500
`define IGC_DEAD_CYC ((`IGC_DEAD_NS * `IGC_CLK_MHZ + 999) / 1000)
`define IGC_MINPW_NS 500
`define IGC_MINPW_CYC ((`IGC_MINPW_NS * `IGC_CLK_MHZ + 999) / 1000)
`define IGC_SHDN_NS 3000
`define IGC_SHDN_CYC ((`IGC_SHDN_NS * `IGC_CLK_MHZ + 999) / 1000)
`define IGC_CARRIER_HZ 20000
`define IGC_PERIOD_CYC ((`IGC_CLK_MHZ * 1000000 + `IGC_CARRIER_HZ - 1) / `IGC_CARRIER_HZ)
`define IGC_RESTART_MS 2000
`define IGC_RESTART_CYC (`IGC_RESTART_MS * `IGC_CLK_MHZ * 1000)
`define IGC_CNT_W 32
`define IGC_PHASES 3

`endif

// *** core/igc_pkg.sv ***
package igc_pkg;
	typedef enum logic [1:0] {
		IGC_RUN,
		IGC_SHDN,
		IGC_WAIT
	} igc_mode_e;

	typedef struct packed {
		logic [2:0] high_side_command;
		logic [2:0] low_side_command;
	} igc_gate_s;

	typedef struct packed {
		logic [2:0] high_req;
		logic [2:0] low_req;
	} igc_req_s;
endpackage

// *** verif/igc_ctrl_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module igc_ctrl_assertions import igc_pkg::*; #(parameter logic [31:0] RESTART_CYC = 32'h000000C8) (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire igc_pkg::igc_req_s req_in,
	input wire logic shutdown_req_in,
	input wire logic fault_line_in,
	input wire logic fault_line_out,
	input wire logic fault_line_oe_out,
	input wire igc_pkg::igc_gate_s gate_out,
	input wire logic fault_active_out,
	input wire logic ready_out
);
	logic [31:0] wcnt, gcnt, ocnt;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wcnt <= '0;
			gcnt <= '0;
			ocnt <= '0;
		end else begin
			wcnt <= (!fault_line_in || ready_out) ? '0 : wcnt + 1;
			gcnt <= $changed(gate_out) ? '0 : gcnt + 1;
			ocnt <= fault_line_oe_out ? ocnt + 1 : '0;
		end
	end
	a_no_shoot: assert property ((gate_out.high_side_command & gate_out.low_side_command) == 3'h0)
		else $error("both sides on");
	a_fault_off: assert property (!fault_line_in |-> ##4 gate_out == '0) else $error("gates on in fault");
	a_fault_latch: assert property ($rose(fault_line_in) |-> ##4 (!ready_out && gate_out == '0) [*8])
		else $error("fault not held");
	a_restart_wait: assert property ($rose(ready_out) |-> wcnt >= RESTART_CYC - 1) else $error("early restart");
	a_gate_space: assert property ($changed(gate_out) && ready_out |-> gcnt >= 74) else $error("gate too soon");
	a_oe_width: assert property ($fell(fault_line_oe_out) |-> ocnt >= 150) else $error("short shutdown");
	a_od_zero: assert property (fault_line_out == 1'b0) else $error("line driven high");
	a_shdn_honour: assert property (shutdown_req_in && ready_out |-> ##[1:160] fault_line_oe_out)
		else $error("shutdown ignored");
endmodule // igc_ctrl_assertions
bind igc_ctrl igc_ctrl_assertions #(.RESTART_CYC(RESTART_CYC)) u_chk (.*);
`default_nettype wire

// *** verif/igc_dev_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module igc_dev_model import igc_pkg::*; (
	input wire igc_pkg::igc_gate_s gate_in,
	input wire logic ctrl_pull_in,
	input wire logic fault_req_in,
	output logic fault_line_out,
	output logic [2:0] high_on_out,
	output logic [2:0] low_on_out
);
	// The pull-up gives the high level, so either party can only ever pull the line low.
	assign fault_line_out = !(ctrl_pull_in || fault_req_in);
	assign high_on_out = fault_line_out ? gate_in.high_side_command : 3'h0;
	assign low_on_out = fault_line_out ? gate_in.low_side_command : 3'h0;
endmodule // igc_dev_model
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
	$display("CHECK FAILED at %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
	import igc_pkg::*;
	logic mclk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic shutdown_req_in = 1'b0;
	logic fault_req = 1'b0;
	igc_req_s req_in = '0;
	igc_gate_s gate_out;
	logic line, oe, od, fault_active_out, ready_out;
	logic [2:0] high_on, low_on;
	int miscompares = 0;
	int samples_checked = 0;
	int n;
	always #10 mclk_in = ~mclk_in;
	igc_ctrl #(.RESTART_CYC(32'h000000C8)) DUT (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .req_in(req_in),
		.shutdown_req_in(shutdown_req_in), .fault_line_in(line), .fault_line_out(od), .fault_line_oe_out(oe),
		.gate_out(gate_out), .fault_active_out(fault_active_out), .ready_out(ready_out));
	igc_dev_model u_dev (.gate_in(gate_out), .ctrl_pull_in(oe), .fault_req_in(fault_req),
		.fault_line_out(line), .high_on_out(high_on), .low_on_out(low_on));
	task automatic step(int k);
		repeat (k) @(negedge mclk_in);
	endtask
	task automatic wait_change();
		igc_gate_s g;
		g = gate_out;
		repeat (2600) begin
			step(1);
			if (gate_out !== g) break;
		end
	endtask
	task automatic wait_ready(int lo);
		n = 0;
		while (ready_out !== 1'b1 && n < 400) begin
			step(1);
			n++;
		end
		`CHK(n >= lo && n < 400, 1'b1)
	endtask
	task automatic final_report();
		$display("compared %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic t_pwm();
		req_in = 6'h0E;
		wait_change();
		`CHK({gate_out, high_on, low_on}, 12'h38E)
		req_in = 6'h07;
		wait_change();
		`CHK(gate_out, 6'h06)
		wait_change();
		`CHK({gate_out, high_on, low_on}, 12'h1C7)
		$display("pwm test done");
	endtask
	task automatic t_fault();
		fault_req = 1'b1;
		step(2);
		`CHK({high_on, low_on}, 6'h00)
		fault_req = 1'b0;
		step(4);
		`CHK({gate_out, ready_out, fault_active_out}, 8'h01)
		// The fault line was released four cycles before this point; the hold-off count began two cycles before it.
		wait_ready(196);
		$display("fault test done");
	endtask
	task automatic t_shdn();
		shutdown_req_in = 1'b1;
		step(160);
		`CHK({oe, line, high_on, low_on}, 8'h80)
		`CHK(od, 1'b0)
		shutdown_req_in = 1'b0;
		wait_ready(199);
		$display("shutdown test done");
	endtask
	initial begin
		step(1);
		`CHK({gate_out, oe, fault_active_out, ready_out}, 9'h002)
		step(19);
		rst_b_in = 1'b1;
		wait_ready(199);
		t_pwm();
		t_fault();
		t_shdn();
		final_report();
	end
	initial begin
		#1000000;
		miscompares++;
		final_report();
	end
endmodule // testbench
`default_nettype wire
